// ==== angle_self_trim_mode_prediction.sv ====
// top: factory trim load, self-trim (continuous in modes 01 and 11, one step per revolution in mode 10), update timing and angle extrapolation
`timescale 1ns/100ps
module angle_self_trim_mode_prediction #(
    parameter int NPAR = self_trim_mode_pkg::NPAR,
    parameter int W    = self_trim_mode_pkg::PAR_W,
    parameter int C0   = self_trim_mode_pkg::CYC_UPD0
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic [NPAR*W-1:0]               fuse_trim,
    input  wire logic [NPAR*W-1:0]               calc_target,
    input  wire self_trim_mode_pkg::sample_t            raw_in,
    input  wire logic                            raw_valid,
    input  wire logic [1:0]                      self_trim_mode,
    input  wire logic [1:0]                      filter_depth_sel,
    input  wire logic                            filter_depth_wr,
    input  wire logic                            extrapolate_en,
    output logic [NPAR*W-1:0]                    trim_out,
    output self_trim_mode_pkg::sample_t                 iface_out,
    output logic                                 iface_upd,
    output logic                                 recalc_req,
    output logic [1:0]                           depth_out
);
    localparam int AW = self_trim_mode_pkg::ANG_W;
    localparam int SB = self_trim_mode_pkg::SPAN_BITS;

    typedef struct packed {
        self_trim_mode_pkg::cal_state_t  st;
        logic [1:0]               depth;
        logic [self_trim_mode_pkg::CNT_W-1:0] cnt;
        logic [AW-1:0]            prev_ang;
        logic [SB-1:0]            last_sec;
        logic [SB:0]              secs_seen;
        logic                     seen_ok;
        logic                     step;
        logic                     load;
        logic                     upd;
        logic                     recalc;
        self_trim_mode_pkg::sample_t     out;
        // registered copy of the stepper values so trim_out comes straight from a flip-flop
        logic [NPAR*W-1:0]        trim;
    } top_state_t;
    top_state_t s_q;
    top_state_t s_d;

    logic [NPAR*W-1:0] trim_val;
    logic [self_trim_mode_pkg::CNT_W-1:0] period;
    logic [SB-1:0]     sec;
    logic [AW:0]       pred;

    // deeper setting doubles the period
    assign period = self_trim_mode_pkg::CNT_W'(C0 << s_q.depth);
    assign sec    = raw_in.angle[AW-1 -: SB];
    // wraps naturally by truncation to the angle width
    assign pred   = {1'b0, raw_in.angle} + {1'b0, raw_in.angle} - {1'b0, s_q.prev_ang};

    genvar gi;
    generate
        for (gi = 0; gi < NPAR; gi++) begin : g_par
            lsb_stepper #(.W(W)) u_stp (
                .clk      (clk),
                .rst_n    (rst_n),
                .load     (s_q.load),
                .load_val (fuse_trim[gi*W +: W]),
                .step     (s_q.step),
                .target   (calc_target[gi*W +: W]),
                .value    (trim_val[gi*W +: W])
            );
        end
    endgenerate

    always_comb begin
        s_d        = s_q;
        s_d.step   = 1'b0;
        s_d.load   = 1'b0;
        s_d.upd    = 1'b0;
        s_d.recalc = 1'b0;
        s_d.trim   = trim_val;
        if (filter_depth_wr) begin
            s_d.depth = filter_depth_sel;
        end
        // interface update tick
        if (s_q.cnt >= period - self_trim_mode_pkg::CNT_W'(1)) begin
            s_d.cnt = '0;
            s_d.upd = 1'b1;
            s_d.out.x = raw_in.x;
            s_d.out.y = raw_in.y;
            if (s_q.depth == 2'h0) begin
                s_d.out.angle    = '0;
                s_d.out.angle_ok = 1'b0;
            end else begin
                s_d.out.angle    = extrapolate_en ? pred[AW-1:0] : raw_in.angle;
                s_d.out.angle_ok = 1'b1;
            end
            s_d.prev_ang = raw_in.angle;
        end else begin
            s_d.cnt = s_q.cnt + self_trim_mode_pkg::CNT_W'(1);
        end
        // revolution tracking: count sector crossings
        if (raw_valid && sec != s_q.last_sec) begin
            s_d.last_sec = sec;
            if (s_q.secs_seen != '1) begin
                s_d.secs_seen = s_q.secs_seen + (SB+1)'(1);
            end
        end
        unique case (s_q.st)
            self_trim_mode_pkg::ST_LOAD: begin
                s_d.load = 1'b1;
                s_d.st   = self_trim_mode_pkg::ST_OBSERVE;
                s_d.secs_seen = '0;
                s_d.last_sec  = sec;
            end
            self_trim_mode_pkg::ST_OBSERVE: begin
                // more than 32 sector crossings is over a full turn
                if (self_trim_mode != self_trim_mode_pkg::MODE_OFF && s_q.secs_seen > (SB+1)'(1 << SB)) begin
                    s_d.seen_ok = 1'b1;
                    s_d.recalc  = 1'b1;
                    s_d.secs_seen = '0;
                    s_d.st = self_trim_mode_pkg::ST_STEP;
                end
            end
            self_trim_mode_pkg::ST_STEP: begin
                unique case (self_trim_mode)
                    self_trim_mode_pkg::MODE_OFF: begin
                        s_d.st = self_trim_mode_pkg::ST_OBSERVE;
                    end
                    self_trim_mode_pkg::MODE_TIME: begin
                        s_d.step = s_d.upd;
                    end
                    self_trim_mode_pkg::MODE_REV: begin
                        // one step, then back to a full observation turn
                        s_d.step = 1'b1;
                        s_d.st   = self_trim_mode_pkg::ST_OBSERVE;
                        s_d.secs_seen = '0;
                    end
                    self_trim_mode_pkg::MODE_SPAN: begin
                        s_d.step = raw_valid && sec != s_q.last_sec;
                    end
                endcase
                // stays in this state in modes 01 and 11: those run continuously
                if (self_trim_mode != self_trim_mode_pkg::MODE_REV && s_q.secs_seen > (SB+1)'(1 << SB)) begin
                    s_d.recalc    = 1'b1;
                    s_d.secs_seen = '0;
                end
            end
            default: begin
                // unused state code: resume observing, since reloading fuse trim would jump the angle
                s_d.st = self_trim_mode_pkg::ST_OBSERVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.st    <= self_trim_mode_pkg::ST_LOAD;
            s_q.depth <= self_trim_mode_pkg::DEPTH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign trim_out   = s_q.trim;
    assign iface_out  = s_q.out;
    assign iface_upd  = s_q.upd;
    assign recalc_req = s_q.recalc;
    assign depth_out  = s_q.depth;

    AST_LOAD_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.load) |-> s_q.st == self_trim_mode_pkg::ST_OBSERVE)
        else $error("fuse load not followed by observation");
    AST_OFF_NO_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (self_trim_mode == self_trim_mode_pkg::MODE_OFF && $past(self_trim_mode) == self_trim_mode_pkg::MODE_OFF) |-> !s_d.step)
        else $error("step while self-trim off");
    AST_STEP_AFTER_TURN: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.step |-> s_q.seen_ok)
        else $error("step before a full revolution");
    AST_REV_ONE_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.step && self_trim_mode == self_trim_mode_pkg::MODE_REV && $stable(self_trim_mode))
        |-> s_q.st == self_trim_mode_pkg::ST_OBSERVE)
        else $error("mode 10 did not return to observation");
    AST_TIME_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.step && $past(self_trim_mode) == self_trim_mode_pkg::MODE_TIME) |-> s_q.upd)
        else $error("mode 01 step off the update tick");
    AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.upd |-> s_q.cnt == '0)
        else $error("update tick without counter restart");
    AST_RAW_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.upd && $past(s_q.depth) == 2'h0) |-> !s_q.out.angle_ok)
        else $error("angle given at depth zero");
    AST_EXTRAPOLATE_EN: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.upd && $past(extrapolate_en) && $past(s_q.depth) != 2'h0)
        |-> s_q.out.angle == AW'(2 * $past(raw_in.angle) - $past(s_q.prev_ang)))
        else $error("extrapolated angle wrong");
    AST_RESET_DEPTH: assert property (@(posedge clk)
        $rose(rst_n) |-> s_q.depth == self_trim_mode_pkg::DEPTH_RST)
        else $error("depth not at reset value");
    AST_RAW_XY: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.upd |-> (s_q.out.x == $past(raw_in.x) && s_q.out.y == $past(raw_in.y)))
        else $error("raw x or y not captured on the update tick");
    AST_SPAN_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.step && $past(self_trim_mode) == self_trim_mode_pkg::MODE_SPAN && $past(s_q.st) == self_trim_mode_pkg::ST_STEP)
        |-> ($past(raw_valid) && $past(sec) != $past(s_q.last_sec)))
        else $error("mode 11 step without a sector crossing");
    AST_DEPTH_WR: assert property (@(posedge clk) disable iff (!rst_n)
        filter_depth_wr |=> s_q.depth == $past(filter_depth_sel))
        else $error("filter depth write not taken");
    AST_LOAD_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.load |-> $past(s_q.st) == self_trim_mode_pkg::ST_LOAD)
        else $error("fuse load outside the start-up state");

    COV_MODE_TIME: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.step && self_trim_mode == self_trim_mode_pkg::MODE_TIME);
    COV_MODE_REV: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.step && self_trim_mode == self_trim_mode_pkg::MODE_REV);
    COV_MODE_SPAN: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.step && self_trim_mode == self_trim_mode_pkg::MODE_SPAN);
    COV_EXTRAPOLATE_EN: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.upd && extrapolate_en);
    COV_RECALC: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.recalc && s_q.st == self_trim_mode_pkg::ST_STEP);
endmodule // angle_self_trim_mode_prediction

// ==== angle_self_trim_mode_prediction_test.sv ====
// self-checking bench for the angle self-trim and extrapolation block
`timescale 1ns/100ps
module angle_self_trim_mode_prediction_test;
    localparam int C0 = 20;
    localparam int LO[4] = '{0, 0, 4, 100};
    localparam int HI[4] = '{0, 0, 7, 100};
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [47:0]          fuse_trim = 48'h0000_0000_0000;
    logic [47:0]          calc_target = {4{12'h064}};
    logic [1:0]           self_trim_mode = 2'h0;
    logic [1:0]           filter_depth_sel = 2'h0;
    logic                 filter_depth_wr = 1'b0;
    logic                 extrapolate_en = 1'b0;
    logic                 spin = 1'b0;
    logic [14:0]          ang_set = 15'h1234;
    logic                 watch = 1'b0;
    self_trim_mode_pkg::sample_t raw_in;
    self_trim_mode_pkg::sample_t iface_out;
    logic                 raw_valid;
    logic [47:0]          trim_out;
    logic [47:0]          prev_trim;
    logic                 iface_upd;
    logic                 recalc_req;
    logic [1:0]           depth_out;
    logic [15:0]          upd_cnt;
    int                   failures = 0;
    int                   cmp_count = 0;
    int                   cycles = 0;

    angle_self_trim_mode_prediction #(.C0(C0)) dut (.clk(clk), .rst_n(rst_n), .fuse_trim(fuse_trim),
        .calc_target(calc_target), .raw_in(raw_in), .raw_valid(raw_valid),
        .self_trim_mode(self_trim_mode), .filter_depth_sel(filter_depth_sel),
        .filter_depth_wr(filter_depth_wr), .extrapolate_en(extrapolate_en), .trim_out(trim_out),
        .iface_out(iface_out), .iface_upd(iface_upd), .recalc_req(recalc_req), .depth_out(depth_out));
    host_model host (.clk(clk), .rst_n(rst_n), .spin(spin), .ang_set(ang_set), .iface_upd(iface_upd),
        .raw_in(raw_in), .raw_valid(raw_valid), .upd_cnt(upd_cnt));

    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under ten thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_hi(input bit rc, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while ((rc ? recalc_req : iface_upd) !== 1'b1 && n < 5000);
        check(n < 5000, 1'b1);
    endtask

    task automatic do_reset(input logic [47:0] fuse);
        rst_n = 1'b0;
        fuse_trim = fuse;
        tick(16);
        rst_n = 1'b1;
        tick(4);
    endtask

    task automatic set_depth(input logic [1:0] d);
        filter_depth_sel = d;
        filter_depth_wr = 1'b1;
        tick(1);
        filter_depth_wr = 1'b0;
    endtask

    task automatic t_reset();
        do_reset(48'h0123_4abc_0f07);
        check(trim_out, fuse_trim);
        check(depth_out, 2'h2);
    endtask

    task automatic t_period();
        int n;
        for (int d = 0; d < 4; d++) begin
            set_depth(d[1:0]);
            wait_hi(1'b0, n);
            wait_hi(1'b0, n);
            wait_hi(1'b0, n);
            check(n, C0 << d);
            check(depth_out, d[1:0]);
            check(iface_out.x, 16'h1234);
            check(iface_out.y, 16'hedcb);
            check({iface_out.angle, iface_out.angle_ok}, (d == 0) ? 16'h0000 : {15'h1234, 1'b1});
        end
    endtask

    task automatic t_extrap();
        int n;
        set_depth(2'h1);
        extrapolate_en = 1'b1;
        ang_set = 15'h0010;
        wait_hi(1'b0, n);
        wait_hi(1'b0, n);
        ang_set = 15'h0005;
        wait_hi(1'b0, n);
        check(iface_out.angle, 15'h7ffa);
        extrapolate_en = 1'b0;
    endtask

    task automatic t_trim(input logic [1:0] m);
        int n;
        int p;
        int f;
        spin = 1'b0;
        self_trim_mode = m;
        do_reset(48'h0000_0000_0000);
        spin = 1'b1;
        if (m != 2'h0) begin
            wait_hi(1'b1, n);
            check(n > 128, 1'b1);
        end
        p = upd_cnt;
        watch = 1'b1;
        tick(800);
        p = upd_cnt - p;
        for (int i = 0; i < 4; i++) begin
            f = trim_out[i*12 +: 12];
            check(f >= ((m == 2'h1) ? p - 1 : LO[m]) && f <= ((m == 2'h1) ? p + 1 : HI[m]), 1'b1);
        end
        watch = 1'b0;
    endtask

    // targets lie above the trim, so every change must be zero or plus one
    always @(negedge clk) begin
        if (watch) begin
            for (int i = 0; i < 4; i++) begin
                check(trim_out[i*12 +: 12] - prev_trim[i*12 +: 12] <= 12'h001, 1'b1);
            end
        end
        prev_trim = trim_out;
    end

    initial begin
        t_reset();
        t_period();
        t_extrap();
        for (int m = 0; m < 4; m++) begin
            t_trim(m[1:0]);
        end
        print_verdict();
    end
endmodule // angle_self_trim_mode_prediction_test

// ==== host_model.sv ====
// host-side model: magnet source that spins on request and an update reader
`timescale 1ns/100ps
module host_model (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            spin,
    input  wire logic [14:0]     ang_set,
    input  wire logic            iface_upd,
    output self_trim_mode_pkg::sample_t raw_in,
    output logic                 raw_valid,
    output logic [15:0]          upd_cnt
);
    logic [14:0] ang_q;
    logic [1:0]  div_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ang_q <= 15'h0000;
            div_q <= 2'h0;
            upd_cnt <= 16'h0000;
        end else begin
            div_q <= div_q + 2'h1;
            // one sector every fourth cycle keeps the sector counts predictable
            if (!spin) begin
                ang_q <= ang_set;
            end else if (div_q == 2'h3) begin
                ang_q <= ang_q + 15'h0400;
            end
            if (iface_upd) begin
                upd_cnt <= upd_cnt + 16'h0001;
            end
        end
    end
    assign raw_in = {{1'b0, ang_q}, ~{1'b0, ang_q}, ang_q, 1'b1};
    assign raw_valid = rst_n;
endmodule // host_model

// ==== lsb_stepper.sv ====
// single trim parameter that slews one lsb per step toward its target
`timescale 1ns/100ps
module lsb_stepper #(
    parameter int W = self_trim_mode_pkg::PAR_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         step,
    input  wire logic [W-1:0] target,
    output logic [W-1:0]      value
);
    typedef struct packed {
        logic [W-1:0] val;
    } stp_state_t;
    stp_state_t s_q;
    stp_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.val = load_val;
        end else if (step) begin
            if ($signed(target) > $signed(s_q.val)) begin
                s_d.val = s_q.val + W'(1);
            end else if ($signed(target) < $signed(s_q.val)) begin
                s_d.val = s_q.val - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign value = s_q.val;

    AST_ONE_LSB: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(load) |-> ($signed(s_q.val - $past(s_q.val)) <= 1 &&
                          $signed($past(s_q.val) - s_q.val) <= 1))
        else $error("trim moved more than one lsb");
endmodule // lsb_stepper

// ==== self_trim_mode_pkg.sv ====
// package: constants and carrier types for the angle self-trim and extrapolation block
package self_trim_mode_pkg;
    localparam int ANG_W = 15;
    localparam int XY_W  = 16;
    localparam int PAR_W = 12;
    localparam int NPAR  = 4;
    localparam int CLK_MHZ = 100;
    // periods in tenths of a microsecond, as printed
    localparam int T_UPD0_NS10 = 213;
    localparam int T_UPD1_NS10 = 427;
    localparam int T_UPD2_NS10 = 853;
    localparam int T_UPD3_NS10 = 1706;
    localparam int CYC_UPD0 = T_UPD0_NS10 * CLK_MHZ / 10;
    localparam int CYC_UPD1 = T_UPD1_NS10 * CLK_MHZ / 10;
    localparam int CYC_UPD2 = T_UPD2_NS10 * CLK_MHZ / 10;
    localparam int CYC_UPD3 = T_UPD3_NS10 * CLK_MHZ / 10;
    localparam int CNT_W = 16;
    localparam logic [1:0] DEPTH_RST = 2'h2;
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_TIME = 2'h1;
    localparam logic [1:0] MODE_REV  = 2'h2;
    localparam logic [1:0] MODE_SPAN = 2'h3;
    // 11.25 degrees is 1/32 of a revolution: top five angle bits
    localparam int SPAN_BITS = 5;
    localparam int T_PON_MS = 7;
    typedef enum logic [1:0] {ST_LOAD, ST_OBSERVE, ST_STEP} cal_state_t;
    typedef struct packed {
        logic [XY_W-1:0]  x;
        logic [XY_W-1:0]  y;
        logic [ANG_W-1:0] angle;
        logic             angle_ok;
    } sample_t;
endpackage
